// *** include/dmagr_pkg.sv ***
package dmagr_pkg;

    // Register placement in configuration space.
    localparam logic [11:0] DMAGR_CTRL_OFFSET    = 12'h290;

    // Field positions of the guarded-region control register.
    localparam int          DMAGR_TOP_MSB        = 31;
    localparam int          DMAGR_TOP_LSB        = 20;
    localparam int          DMAGR_SIZE_MSB       = 11;
    localparam int          DMAGR_SIZE_LSB       = 4;
    localparam int          DMAGR_CMD_BIT        = 2;
    localparam int          DMAGR_STS_BIT        = 1;
    localparam int          DMAGR_LOCK_BIT       = 0;
    localparam int          DMAGR_LOCKED_MSB     = 19;

    // Widths derived from the field positions.
    localparam int          DMAGR_TOP_W          = DMAGR_TOP_MSB - DMAGR_TOP_LSB + 1;
    localparam int          DMAGR_SIZE_W         = DMAGR_SIZE_MSB - DMAGR_SIZE_LSB + 1;

    // One megabyte is one step of both the top and the size field.
    localparam int          DMAGR_MB_SHIFT       = 20;

    // Reset values.
    localparam logic [31:0] DMAGR_CTRL_RESET     = 32'h0000_0000;
    localparam logic [11:0] DMAGR_TOP_RESET      = 12'h000;
    localparam logic [7:0]  DMAGR_SIZE_RESET     = 8'h00;
    localparam logic        DMAGR_BIT_RESET      = 1'b0;

    // Largest guarded size in megabytes, the full reach of the size field.
    localparam logic [7:0]  DMAGR_SIZE_MAX_MB    = 8'hff;

    // Default translated DMA address width.
    localparam int          DMAGR_ADDR_W_DEFAULT = 46;

endpackage

// *** src/dmagr_guard.sv ***
`timescale 1ns/1ps


module dmagr_guard #(
    parameter int ADDR_W = dmagr_pkg::DMAGR_ADDR_W_DEFAULT
) (
    // Clock and reset.
    input  wire logic                                  core_clk,
    input  wire logic                                  sys_rst,
    // Configuration space access.
    input  wire logic                                  cfg_wr_en,
    input  wire logic                                  cfg_rd_en,
    input  wire logic [11:0]                           cfg_addr,
    input  wire logic [3:0]                            cfg_be,
    input  wire logic [31:0]                           cfg_wdata,
    output logic [31:0]                                cfg_rdata,
    output logic                                       cfg_rd_valid,
    // Memory map state from the system address decoder.
    input  wire logic                                  smm_segment_en,
    input  wire logic [dmagr_pkg::DMAGR_TOP_W-1:0]     smm_segment_base,
    input  wire logic [dmagr_pkg::DMAGR_TOP_W-1:0]     mgmt_firmware_stolen_memory_base,
    // Inbound DMA request after translation.
    input  wire logic                                  req_valid,
    input  wire logic [ADDR_W-1:0]                     req_addr,
    input  wire logic                                  req_write,
    input  wire logic                                  req_from_remap_engine,
    input  wire logic                                  req_other_deny,
    // Verdict, one cycle after the request.
    output logic                                       resp_valid,
    output logic [ADDR_W-1:0]                          resp_addr,
    output logic                                       resp_write,
    output logic                                       resp_allow,
    output logic                                       resp_guard_fault,
    // Protection state for neighbouring logic.
    output logic                                       guard_active
);
    import dmagr_pkg::*;

    // The top field covers address bits 31:20, so narrower addresses cannot hold it.
    if (ADDR_W < 32 || ADDR_W > 64) begin : g_addr_w_check
        $error("dmagr_guard: ADDR_W must lie between 32 and 64");
    end

    // Register fields.
    logic [DMAGR_TOP_W-1:0]  region_top;
    logic [DMAGR_SIZE_W-1:0] region_size;
    logic                    prot_cmd;
    logic                    prot_sts;
    logic                    lock;

    // Decoded access terms.
    logic                    ctrl_sel;
    logic                    ctrl_wr;
    logic                    ctrl_rd;
    logic                    fields_writable;
    logic [31:0]             ctrl_value;

    // Next values of the writable fields.
    logic [DMAGR_SIZE_W-1:0] next_region_size;
    logic                    next_prot_cmd;
    logic                    next_lock;

    // Region check terms.
    logic [DMAGR_TOP_W-1:0]  next_region_top;
    logic                    range_hit;
    logic                    guard_deny;
    logic                    check_applies;

    assign ctrl_sel = (cfg_addr[11:2] == DMAGR_CTRL_OFFSET[11:2]);
    assign ctrl_wr  = cfg_wr_en && ctrl_sel;
    assign ctrl_rd  = cfg_rd_en && ctrl_sel;

    // The lock taken before the write decides, so a write that sets the lock
    // may still carry the other field values in the same transaction.
    assign fields_writable = ctrl_wr && !lock;

    // Size straddles byte lanes 0 and 1, so each half follows its own enable.
    always_comb begin
        next_region_size = region_size;
        if (fields_writable) begin
            if (cfg_be[0]) begin
                next_region_size[3:0] = cfg_wdata[7:DMAGR_SIZE_LSB];
            end
            if (cfg_be[1]) begin
                next_region_size[7:4] = cfg_wdata[DMAGR_SIZE_MSB:8];
            end
        end
    end

    always_comb begin
        next_prot_cmd = prot_cmd;
        if (fields_writable && cfg_be[0]) begin
            next_prot_cmd = cfg_wdata[DMAGR_CMD_BIT];
        end
    end

    // The lock only ever sets; writing zero does nothing and only reset clears it.
    always_comb begin
        next_lock = lock;
        if (ctrl_wr && cfg_be[0] && cfg_wdata[DMAGR_LOCK_BIT]) begin
            next_lock = 1'b1;
        end
    end

    // Top of region follows the segment base, or the stolen-memory base when
    // the segment is off, since that is where the segment would have started.
    always_comb begin
        if (smm_segment_en) begin
            next_region_top = smm_segment_base;
        end else begin
            next_region_top = mgmt_firmware_stolen_memory_base;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            region_top <= DMAGR_TOP_RESET;
        end else begin
            region_top <= next_region_top;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            region_size <= DMAGR_SIZE_RESET;
        end else begin
            region_size <= next_region_size;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prot_cmd <= DMAGR_BIT_RESET;
        end else begin
            prot_cmd <= next_prot_cmd;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lock <= DMAGR_BIT_RESET;
        end else begin
            lock <= next_lock;
        end
    end

    // Status trails the command by one cycle, the moment the check uses the new setting.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prot_sts <= DMAGR_BIT_RESET;
        end else begin
            prot_sts <= prot_cmd;
        end
    end

    assign guard_active = prot_sts;

    // Read view; unused bits 19:12 and 3 read as zero.
    always_comb begin
        ctrl_value                              = DMAGR_CTRL_RESET;
        ctrl_value[DMAGR_TOP_MSB:DMAGR_TOP_LSB] = region_top;
        ctrl_value[DMAGR_SIZE_MSB:DMAGR_SIZE_LSB] = region_size;
        ctrl_value[DMAGR_CMD_BIT]               = prot_cmd;
        ctrl_value[DMAGR_STS_BIT]               = prot_sts;
        ctrl_value[DMAGR_LOCK_BIT]              = lock;
    end

    // Reads of any other offset in this space answer with zero.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfg_rdata <= DMAGR_CTRL_RESET;
        end else if (cfg_rd_en) begin
            cfg_rdata <= ctrl_rd ? ctrl_value : DMAGR_CTRL_RESET;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfg_rd_valid <= 1'b0;
        end else begin
            cfg_rd_valid <= cfg_rd_en;
        end
    end

    dmagr_range_check #(
        .ADDR_W      (ADDR_W)
    ) u_range_check (
        .region_top  (region_top),
        .region_size (region_size),
        .addr        (req_addr),
        .hit         (range_hit)
    );

    // The remap engines own the tables that may live inside the region, so
    // their own fetches and updates bypass the check.
    assign check_applies = prot_sts && !req_from_remap_engine;

    // The request address is already translated; a hit faults regardless of
    // what translation concluded.
    assign guard_deny = check_applies && range_hit;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            resp_valid <= 1'b0;
        end else begin
            resp_valid <= req_valid;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            resp_addr  <= '0;
            resp_write <= 1'b0;
        end else if (req_valid) begin
            resp_addr  <= req_addr;
            resp_write <= req_write;
        end
    end

    // Denials combine by OR: any single check blocks the request.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            resp_allow       <= 1'b0;
            resp_guard_fault <= 1'b0;
        end else begin
            resp_allow       <= req_valid && !guard_deny && !req_other_deny;
            resp_guard_fault <= req_valid && guard_deny;
        end
    end

endmodule

// *** src/dmagr_range_check.sv ***
`timescale 1ns/1ps

module dmagr_range_check #(
    parameter int ADDR_W = dmagr_pkg::DMAGR_ADDR_W_DEFAULT
) (
    // Region description.
    input  wire logic [dmagr_pkg::DMAGR_TOP_W-1:0]  region_top,
    input  wire logic [dmagr_pkg::DMAGR_SIZE_W-1:0] region_size,
    // Address under test.
    input  wire logic [ADDR_W-1:0]                  addr,
    // Result.
    output logic                                    hit
);
    import dmagr_pkg::*;

    localparam int MB_ADDR_W = ADDR_W - DMAGR_MB_SHIFT;

    logic [MB_ADDR_W-1:0] addr_mb;
    logic [MB_ADDR_W-1:0] top_mb;
    logic [MB_ADDR_W-1:0] size_mb;
    logic [MB_ADDR_W-1:0] base_mb;

    // Both bounds sit on megabyte boundaries, so only the megabyte index of the address matters.
    assign addr_mb = addr[ADDR_W-1:DMAGR_MB_SHIFT];
    assign top_mb  = MB_ADDR_W'(region_top);
    assign size_mb = MB_ADDR_W'(region_size);

    // A size larger than the top clamps the base at zero rather than wrapping to high memory.
    assign base_mb = (size_mb > top_mb) ? '0 : MB_ADDR_W'(top_mb - size_mb);

    // Guarded span is base up to top minus one; a zero size guards nothing.
    assign hit = (region_size != '0) && (addr_mb >= base_mb) && (addr_mb < top_mb);

endmodule

// *** verification/dmagr_dma_src.sv ***
`timescale 1ns/1ps

module dmagr_dma_src #(
    parameter int ADDR_W = 46
) (
    // Stimulus from the bench.
    input wire logic              core_clk,
    input wire logic              go,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              remap,
    input wire logic              deny,
    // Request toward the guard.
    output logic                  req_valid,
    output logic [ADDR_W-1:0]     req_addr,
    output logic                  req_write,
    output logic                  req_from_remap_engine,
    output logic                  req_other_deny
);
    // Idle cycles show inverted qualifiers so a stale value never passes for a request.
    always_ff @(posedge core_clk) begin
        req_valid <= go;
        req_addr <= go ? addr : ~addr;
        req_write <= go ? addr[3] : ~addr[3];
        req_from_remap_engine <= go ? remap : ~remap;
        req_other_deny <= go ? deny : ~deny;
    end
endmodule

// *** verification/dmagr_guard_chk.sv ***
`timescale 1ns/1ps

module dmagr_guard_chk #(
    parameter int ADDR_W = 46
) (
    // Clock and reset.
    input wire logic              core_clk,
    input wire logic              sys_rst,
    // Configuration side.
    input wire logic              cfg_wr_en,
    input wire logic              cfg_rd_en,
    input wire logic [11:0]       cfg_addr,
    input wire logic [3:0]        cfg_be,
    input wire logic [31:0]       cfg_wdata,
    input wire logic              cfg_rd_valid,
    // Request and verdict.
    input wire logic              req_valid,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic              req_from_remap_engine,
    input wire logic              req_other_deny,
    input wire logic              resp_valid,
    input wire logic [ADDR_W-1:0] resp_addr,
    input wire logic              resp_allow,
    input wire logic              resp_guard_fault,
    input wire logic              guard_active
);
    import dmagr_pkg::*;
    logic lk;
    wire  hit_wr = cfg_wr_en && cfg_addr[11:2] == DMAGR_CTRL_OFFSET[11:2] && cfg_be[0];
    // The shadow lock lets the checker know which command writes must land.
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            lk <= 1'b0;
        else if (hit_wr && cfg_wdata[DMAGR_LOCK_BIT])
            lk <= 1'b1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_cmd_wr;
        hit_wr && !lk;
    endsequence
    sequence s_req_clean;
        req_valid && !req_other_deny;
    endsequence
    a_resp_timing: assert property (1 |=> resp_valid == $past(req_valid))
        else $error("verdict timing wrong");
    a_read_answer: assert property (1 |=> cfg_rd_valid == $past(cfg_rd_en))
        else $error("read answer timing wrong");
    a_addr_copy: assert property (req_valid |=> resp_addr == $past(req_addr))
        else $error("verdict address differs");
    a_remap_free: assert property (s_req_clean ##0 req_from_remap_engine |=> resp_allow && !resp_guard_fault)
        else $error("remap engine access blocked");
    a_other_blocks: assert property (req_valid && req_other_deny |=> !resp_allow)
        else $error("other denial ignored");
    a_idle_pass: assert property (s_req_clean ##0 !guard_active |=> resp_allow)
        else $error("blocked while inactive");
    a_fault_cause: assert property (resp_guard_fault |-> resp_valid && !resp_allow && $past(guard_active))
        else $error("fault without active guard");
    a_allow_rule: assert property (resp_valid |-> resp_allow == (!$past(req_other_deny) && !resp_guard_fault))
        else $error("allow not the and of checks");
    a_cmd_status: assert property (s_cmd_wr |=> ##1 guard_active == $past(cfg_wdata[DMAGR_CMD_BIT], 2))
        else $error("status does not follow command");
    a_lock_freeze: assert property (lk && $past(lk) |=> $stable(guard_active))
        else $error("locked command changed");
endmodule

// *** verification/dmagr_guard_tb.sv ***
`timescale 1ns/1ps

module dmagr_guard_tb;
    typedef struct packed {logic cmd; logic en; logic [7:0] size; logic rm; logic dn; logic [31:0] a;
                           logic al; logic fl;} dmagr_row_s;
    localparam int         ADDR_W = 32;
    localparam dmagr_row_s ROWS [13] = '{
        '{1, 1, 8'h02, 0, 0, 32'h0FE0_0000, 0, 1}, '{1, 1, 8'h02, 0, 0, 32'h0FDF_FFFF, 1, 0},
        '{1, 1, 8'h02, 0, 0, 32'h0FFF_FFFF, 0, 1}, '{1, 1, 8'h02, 0, 0, 32'h1000_0000, 1, 0},
        '{1, 1, 8'h02, 1, 0, 32'h0FF0_0000, 1, 0}, '{1, 1, 8'h02, 0, 1, 32'h0FF0_0000, 0, 1},
        '{1, 1, 8'h02, 0, 1, 32'h0000_0000, 0, 0}, '{1, 1, 8'h00, 0, 0, 32'h0FFF_FFFF, 1, 0},
        '{1, 1, 8'hFF, 0, 0, 32'h0010_0000, 0, 1}, '{1, 1, 8'hFF, 0, 0, 32'h000F_FFFF, 1, 0},
        '{1, 0, 8'h02, 0, 0, 32'h07F0_0000, 0, 1}, '{1, 0, 8'h02, 0, 0, 32'h0FF0_0000, 1, 0},
        '{0, 1, 8'h02, 0, 0, 32'h0FF0_0000, 1, 0}};
    logic              core_clk, sys_rst, cfg_wr_en, cfg_rd_en, cfg_rd_valid, smm_segment_en, go, remap, deny;
    logic              req_valid, req_write, req_from_remap_engine, req_other_deny, guard_active;
    logic              resp_valid, resp_write, resp_allow, resp_guard_fault;
    logic [11:0]       cfg_addr, smm_segment_base, mgmt_firmware_stolen_memory_base;
    logic [3:0]        cfg_be;
    logic [31:0]       cfg_wdata, cfg_rdata, addr, req_addr, resp_addr;
    int                failures = 0, comparisons = 0, cycles = 0;

    dmagr_guard #(.ADDR_W(ADDR_W)) dut_u (.*);
    dmagr_dma_src #(.ADDR_W(ADDR_W)) src_u (.*);

    task conclude;
        $display("counts: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic ok, input string msg);
        comparisons++;
        if (!ok) begin
            failures++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask
    task cfg_wr(input logic [31:0] d);
        @(posedge core_clk);
        cfg_wr_en <= 1'b1;
        cfg_addr <= 12'h290;
        cfg_wdata <= d;
        @(posedge core_clk);
        cfg_wr_en <= 1'b0;
    endtask
    task cfg_rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        cfg_rd_en <= 1'b1;
        cfg_addr <= a;
        @(posedge core_clk);
        cfg_rd_en <= 1'b0;
        #1 chk(cfg_rd_valid === 1'b1 && cfg_rdata === exp, "register read");
    endtask
    task req(input logic [31:0] a, input logic rm, dn, al, fl);
        @(posedge core_clk);
        go <= 1'b1;
        addr <= a;
        remap <= rm;
        deny <= dn;
        @(posedge core_clk);
        go <= 1'b0;
        @(posedge core_clk);
        #1 chk(resp_valid === 1'b1 && resp_allow === al && resp_guard_fault === fl && resp_addr === a, "verdict");
        chk(resp_write === a[3], "verdict direction");
    endtask

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // About 150 cycles are needed; the ceiling leaves a wide margin.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        {sys_rst, cfg_be} = 5'h1F;
        {cfg_wr_en, cfg_rd_en, go, remap, deny, cfg_addr, cfg_wdata, addr} = '0;
        {smm_segment_en, smm_segment_base, mgmt_firmware_stolen_memory_base} = {1'b1, 12'h100, 12'h080};
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1 chk(guard_active === 1'b0 && resp_valid === 1'b0, "outputs after reset");
        cfg_rd(12'h290, 32'h1000_0000);
        cfg_rd(12'h294, 32'h0000_0000);
        $display("test reset done");
        foreach (ROWS[i]) begin
            @(posedge core_clk);
            smm_segment_en <= ROWS[i].en;
            cfg_wr({20'h0_0000, ROWS[i].size, 1'b0, ROWS[i].cmd, 2'h0});
            repeat (2) @(posedge core_clk);
            #1 chk(guard_active === ROWS[i].cmd, "status flag");
            req(ROWS[i].a, ROWS[i].rm, ROWS[i].dn, ROWS[i].al, ROWS[i].fl);
        end
        $display("test table done");
        cfg_wr(32'hFFF0_0025);
        cfg_wr(32'h0000_0000);
        cfg_rd(12'h290, 32'h1000_0027);
        req(32'h0FF0_0000, 1'b0, 1'b0, 1'b0, 1'b1);
        @(posedge core_clk);
        smm_segment_base <= 12'h0C0;
        cfg_rd(12'h290, 32'h0C00_0027);
        $display("test lock done");
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        cfg_rd(12'h290, 32'h0C00_0000);
        cfg_wr(32'h0000_0004);
        repeat (2) @(posedge core_clk);
        cfg_rd(12'h290, 32'h0C00_0006);
        $display("test second reset done");
        conclude();
    end
endmodule

bind dmagr_guard dmagr_guard_chk #(.ADDR_W(ADDR_W)) chk_u (.*);
